/* File: design/pcp_port_pins.sv */
// eight-pin port with direction, pull-ups, change and edge interrupt flags, timer wrap flag
// How it works
// - direction 1 floats pin, 0 drives latch
// - port read gives pins, write sets latch
// - bit set/clear writes are read-modify-write of pins
// - option bit 7 clear enables pull-ups on all input pins
// - output pins never get a pull-up
// - pull-ups off after power-on reset
// - upper pins compared with value at last port access
// - only input upper pins can mismatch
// - ORed mismatches set change flag bit 0
// - mismatch keeps setting; port access re-latches
// - change during port access still sets flag
// - change interrupt wakes device from halt
// - edge select bit 6 chooses rise/fall
// - selected edge sets external flag bit 1
// - external enable bit 4 gates request
// - external wake needs enable before halt
// - after wake, vector only if global enable
// - timer wrap FFh to 00h sets bit 2
// - timer enable bit 5 gates request
// - change enable bit gates change request
module pcp_port_pins
(
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  // register port
  input  wire pcp_pkg::pcp_bus_req_type busReq,
  output logic [pcp_pkg::DATA_W-1:0]   busRdata,
  // pins
  input  wire logic [7:0]              padIn,
  output logic [7:0]                   padOut,
  output logic [7:0]                   padOe,
  output logic [7:0]                   padPullupEn,
  // timer count enable
  input  wire logic                    timerTick,
  // core signalling
  output logic                         intReq,
  output logic                         halted,
  output logic                         wakePulse,
  output logic                         vectorJump
);

  logic [7:0]          syncA_r;
  logic [7:0]          syncB_r;
  logic                extPrev_r;
  logic [7:0]          portLatch_r;
  logic [7:0]          dir_r;
  logic [7:0]          option_r;
  logic [7:0]          intCtl_r;
  logic [7:0]          intCtl_nxt;
  logic [7:0]          timer_r;
  logic [3:0]          oldUpper_r;
  logic                extEnAtHalt_r;
  pcp_pkg::pcp_pwr_type pwr_r;
  logic [7:0]          rdata_r;
  logic [7:0]          padOut_r;
  logic [7:0]          padOe_r;
  logic [7:0]          pullup_r;
  logic                intReq_r;
  logic                wake_r;
  logic                vector_r;

  logic                wrPort;
  logic                wrSet;
  logic                wrClr;
  logic                portAccess;
  logic                wrIntCtl;
  logic                wrTimer;
  logic [3:0]          mismatchBits;
  logic                mismatch;
  logic                extRise;
  logic                extFall;
  logic                extEdge;
  logic                timerWrap;
  logic                wakeCause;

  // decode
  always_comb
  begin
    wrPort   = busReq.wr && (busReq.addr == pcp_pkg::ADDR_PORT);
    wrSet    = busReq.wr && (busReq.addr == pcp_pkg::ADDR_PORT_SET);
    wrClr    = busReq.wr && (busReq.addr == pcp_pkg::ADDR_PORT_CLR);
    wrIntCtl = busReq.wr && (busReq.addr == pcp_pkg::ADDR_INTCTL);
    wrTimer  = busReq.wr && (busReq.addr == pcp_pkg::ADDR_TIMER);
    portAccess = wrPort || wrSet || wrClr
                 || (busReq.rd && (busReq.addr == pcp_pkg::ADDR_PORT));
  end

  // two-stage pin synchroniser, free running so reset leaves it primed
  always_ff @(posedge core_clk)
  begin
    syncA_r <= padIn;
    syncB_r <= syncA_r;
  end

  // output latch, set/clear writes start from sampled pins
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      portLatch_r <= pcp_pkg::RST_PORT;
    else if (wrPort)
      portLatch_r <= busReq.wdata;
    else if (wrSet)
      portLatch_r <= syncB_r | busReq.wdata;
    else if (wrClr)
      portLatch_r <= syncB_r & ~busReq.wdata;
  end

  // direction and option registers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      dir_r    <= pcp_pkg::RST_DIR;
      option_r <= pcp_pkg::RST_OPTION;
    end
    else if (busReq.wr && (busReq.addr == pcp_pkg::ADDR_DIR))
      dir_r <= busReq.wdata;
    else if (busReq.wr && (busReq.addr == pcp_pkg::ADDR_OPTION))
      option_r <= busReq.wdata;
  end

  // pin drivers and pull-ups
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      padOut_r <= 8'h00;
      padOe_r  <= 8'h00;
      pullup_r <= 8'h00;
    end
    else
    begin
      padOut_r <= portLatch_r;
      padOe_r  <= ~dir_r;
      pullup_r <= dir_r & {8{~option_r[pcp_pkg::OPT_PULLUP_DIS_N]}};
    end
  end

  // change comparison against last access value
  assign mismatchBits = (syncB_r[pcp_pkg::CHG_PIN_HI:pcp_pkg::CHG_PIN_LO] ^ oldUpper_r)
                        & dir_r[pcp_pkg::CHG_PIN_HI:pcp_pkg::CHG_PIN_LO];
  assign mismatch     = |mismatchBits;

  // a change landing on the re-latch cycle still sets the change flag
  always_ff @(posedge core_clk)
  begin
    if (!nrst || portAccess)
      oldUpper_r <= syncB_r[pcp_pkg::CHG_PIN_HI:pcp_pkg::CHG_PIN_LO];
  end

  // edge history tracks the pin through reset: no false edge after release
  always_ff @(posedge core_clk)
    extPrev_r <= syncB_r[pcp_pkg::EXT_PIN];

  assign extRise = syncB_r[pcp_pkg::EXT_PIN] && !extPrev_r;
  assign extFall = !syncB_r[pcp_pkg::EXT_PIN] && extPrev_r;
  assign extEdge = option_r[pcp_pkg::OPT_EDGE_SEL] ? extRise : extFall;

  // timer count
  assign timerWrap = timerTick && !wrTimer && (timer_r == pcp_pkg::TIMER_TOP);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      timer_r <= pcp_pkg::RST_TIMER;
    else if (wrTimer)
      timer_r <= busReq.wdata;
    else if (timerTick)
      timer_r <= timer_r + 8'h01;
  end

  // flags: event set wins over a software clear
  always_comb
  begin
    intCtl_nxt = wrIntCtl ? busReq.wdata : intCtl_r;
    if (mismatch)
      intCtl_nxt[pcp_pkg::IC_PIN_CHG_FLAG] = 1'b1;
    if (extEdge)
      intCtl_nxt[pcp_pkg::IC_EXT_FLAG] = 1'b1;
    if (timerWrap)
      intCtl_nxt[pcp_pkg::IC_WRAP_FLAG] = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      intCtl_r <= pcp_pkg::RST_INTCTL;
    else
      intCtl_r <= intCtl_nxt;
  end

  // interrupt request
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      intReq_r <= 1'b0;
    else
      intReq_r <= intCtl_r[pcp_pkg::IC_GLOBAL_EN]
                  && ((intCtl_r[pcp_pkg::IC_PIN_CHG_FLAG]
                       && intCtl_r[pcp_pkg::IC_PIN_CHG_EN])
                      || (intCtl_r[pcp_pkg::IC_EXT_FLAG]
                          && intCtl_r[pcp_pkg::IC_EXT_EN])
                      || (intCtl_r[pcp_pkg::IC_WRAP_FLAG]
                          && intCtl_r[pcp_pkg::IC_WRAP_EN]));
  end

  // halt and wake
  assign wakeCause = (intCtl_r[pcp_pkg::IC_PIN_CHG_FLAG]
                      && intCtl_r[pcp_pkg::IC_PIN_CHG_EN])
                     || (intCtl_r[pcp_pkg::IC_EXT_FLAG] && extEnAtHalt_r);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pwr_r         <= pcp_pkg::PCP_RUN;
      extEnAtHalt_r <= 1'b0;
      wake_r        <= 1'b0;
      vector_r      <= 1'b0;
    end
    else
    begin
      wake_r   <= 1'b0;
      vector_r <= 1'b0;
      case (pwr_r)
        pcp_pkg::PCP_RUN:
        begin
          if (busReq.wr && (busReq.addr == pcp_pkg::ADDR_POWER)
              && busReq.wdata[pcp_pkg::PWR_HALT])
          begin
            pwr_r         <= pcp_pkg::PCP_HALT;
            extEnAtHalt_r <= intCtl_r[pcp_pkg::IC_EXT_EN];
          end
        end
        pcp_pkg::PCP_HALT:
        begin
          if (wakeCause)
          begin
            pwr_r    <= pcp_pkg::PCP_RUN;
            wake_r   <= 1'b1;
            vector_r <= intCtl_r[pcp_pkg::IC_GLOBAL_EN];
          end
        end
        default:
          pwr_r <= pcp_pkg::PCP_RUN;
      endcase
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      rdata_r <= 8'h00;
    else if (!busReq.rd)
      rdata_r <= 8'h00;
    else if (busReq.addr == pcp_pkg::ADDR_PORT)
      rdata_r <= syncB_r;
    else if (busReq.addr == pcp_pkg::ADDR_DIR)
      rdata_r <= dir_r;
    else if (busReq.addr == pcp_pkg::ADDR_OPTION)
      rdata_r <= option_r;
    else if (busReq.addr == pcp_pkg::ADDR_INTCTL)
      rdata_r <= intCtl_r;
    else if (busReq.addr == pcp_pkg::ADDR_TIMER)
      rdata_r <= timer_r;
    else if (busReq.addr == pcp_pkg::ADDR_POWER)
      rdata_r <= {7'h00, pwr_r == pcp_pkg::PCP_HALT};
    else
      rdata_r <= 8'h00;
  end

  assign busRdata    = rdata_r;
  assign padOut      = padOut_r;
  assign padOe       = padOe_r;
  assign padPullupEn = pullup_r;
  assign intReq      = intReq_r;
  assign halted      = (pwr_r == pcp_pkg::PCP_HALT);
  assign wakePulse   = wake_r;
  assign vectorJump  = vector_r;

  // checks
  sequence s_portRead;
    busReq.rd && (busReq.addr == pcp_pkg::ADDR_PORT);
  endsequence

  sequence s_haltEntry;
    !halted ##1 halted;
  endsequence

  property p_driveFollowsDir;
    @(posedge core_clk) disable iff (!nrst)
    ##1 (padOe == ~$past(dir_r));
  endproperty
  a_driveFollowsDir: assert property (p_driveFollowsDir)
    else $error("pin drive does not follow direction");

  property p_portReadPins;
    @(posedge core_clk) disable iff (!nrst)
    s_portRead |=> (busRdata == $past(syncB_r));
  endproperty
  a_portReadPins: assert property (p_portReadPins)
    else $error("port read did not return pin levels");

  property p_setIsRmw;
    @(posedge core_clk) disable iff (!nrst)
    wrSet |=> (portLatch_r == ($past(syncB_r) | $past(busReq.wdata)));
  endproperty
  a_setIsRmw: assert property (p_setIsRmw)
    else $error("bit set write did not start from pin levels");

  property p_pullupOff;
    @(posedge core_clk) disable iff (!nrst)
    ##1 ((padPullupEn & ~$past(dir_r)) == 8'h00);
  endproperty
  a_pullupOff: assert property (p_pullupOff)
    else $error("pull-up on an output pin");

  property p_pullupResetOff;
    @(posedge core_clk)
    !nrst ##1 nrst |-> (padPullupEn == 8'h00) ##1 (padPullupEn == 8'h00);
  endproperty
  a_pullupResetOff: assert property (p_pullupResetOff)
    else $error("pull-ups on after reset");

  property p_outputNoMismatch;
    @(posedge core_clk) disable iff (!nrst)
    (dir_r[7:4] == 4'h0) |-> !mismatch;
  endproperty
  a_outputNoMismatch: assert property (p_outputNoMismatch)
    else $error("output pin produced a mismatch");

  property p_mismatchSetsFlag;
    @(posedge core_clk) disable iff (!nrst)
    mismatch |=> intCtl_r[pcp_pkg::IC_PIN_CHG_FLAG];
  endproperty
  a_mismatchSetsFlag: assert property (p_mismatchSetsFlag)
    else $error("mismatch did not set change flag");

  property p_accessEndsMismatch;
    @(posedge core_clk) disable iff (!nrst)
    s_portRead ##1 ($stable(syncB_r) && $stable(dir_r)) |-> !mismatch;
  endproperty
  a_accessEndsMismatch: assert property (p_accessEndsMismatch)
    else $error("port read did not end mismatch");

  property p_edgeSetsFlag;
    @(posedge core_clk) disable iff (!nrst)
    (option_r[pcp_pkg::OPT_EDGE_SEL] && $rose(syncB_r[0]))
      |=> intCtl_r[pcp_pkg::IC_EXT_FLAG];
  endproperty
  a_edgeSetsFlag: assert property (p_edgeSetsFlag)
    else $error("rising edge did not set external flag");

  property p_extDisabled;
    @(posedge core_clk) disable iff (!nrst)
    (!intCtl_r[pcp_pkg::IC_EXT_EN] && !intCtl_r[pcp_pkg::IC_PIN_CHG_EN]
     && !intCtl_r[pcp_pkg::IC_WRAP_EN]) |=> !intReq;
  endproperty
  a_extDisabled: assert property (p_extDisabled)
    else $error("request raised with all enables clear");

  property p_wrapFlag;
    @(posedge core_clk) disable iff (!nrst)
    timerWrap |=> (timer_r == 8'h00) && intCtl_r[pcp_pkg::IC_WRAP_FLAG];
  endproperty
  a_wrapFlag: assert property (p_wrapFlag)
    else $error("timer wrap did not set flag");

  property p_flagSticky;
    @(posedge core_clk) disable iff (!nrst)
    (intCtl_r[pcp_pkg::IC_EXT_FLAG] && !wrIntCtl) |=> intCtl_r[pcp_pkg::IC_EXT_FLAG];
  endproperty
  a_flagSticky: assert property (p_flagSticky)
    else $error("external flag dropped without software write");

  property p_wakeVector;
    @(posedge core_clk) disable iff (!nrst)
    (halted && wakeCause) |=> wakePulse && !halted
      && (vectorJump == $past(intCtl_r[pcp_pkg::IC_GLOBAL_EN]));
  endproperty
  a_wakeVector: assert property (p_wakeVector)
    else $error("wake or vector decision wrong");

  property p_extWakeNeedsEnable;
    @(posedge core_clk) disable iff (!nrst)
    s_haltEntry ##0 (!extEnAtHalt_r && !intCtl_r[pcp_pkg::IC_PIN_CHG_EN])
      ##1 !intCtl_r[pcp_pkg::IC_PIN_CHG_EN] |-> !wakePulse;
  endproperty
  a_extWakeNeedsEnable: assert property (p_extWakeNeedsEnable)
    else $error("external wake without enable before halt");

endmodule

/* File: design/pcp_pkg.sv */
// shared constants and types of the port-pin block with change interrupts
package pcp_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_PORT     = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_DIR      = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_OPTION   = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_INTCTL   = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_TIMER    = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_POWER    = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_PORT_SET = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_PORT_CLR = 3'h7;

  // option register fields
  localparam int OPT_PULLUP_DIS_N = 7;
  localparam int OPT_EDGE_SEL     = 6;

  // interrupt control register fields
  localparam int IC_PIN_CHG_FLAG = 0;
  localparam int IC_EXT_FLAG     = 1;
  localparam int IC_WRAP_FLAG    = 2;
  localparam int IC_PIN_CHG_EN   = 3;
  localparam int IC_EXT_EN       = 4;
  localparam int IC_WRAP_EN      = 5;
  localparam int IC_GLOBAL_EN    = 7;

  // power control field
  localparam int PWR_HALT = 0;

  // pin positions
  localparam int EXT_PIN     = 0;
  localparam int CHG_PIN_LO  = 4;
  localparam int CHG_PIN_HI  = 7;

  // reset values and timer wrap value
  localparam logic [DATA_W-1:0] RST_PORT   = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIR    = 8'hFF;
  localparam logic [DATA_W-1:0] RST_OPTION = 8'hFF;
  localparam logic [DATA_W-1:0] RST_INTCTL = 8'h00;
  localparam logic [DATA_W-1:0] RST_TIMER  = 8'h00;
  localparam logic [DATA_W-1:0] TIMER_TOP  = 8'hFF;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } pcp_bus_req_type;

  // halt state
  typedef enum logic [0:0] {
    PCP_RUN  = 1'b0,
    PCP_HALT = 1'b1
  } pcp_pwr_type;

endpackage

/* File: test/pcp_pin_model.sv */
// pin-side model: keys, weak pull-ups and floating lines
module pcp_pin_model
(
  // clock
  input  wire logic       core_clk,
  // device pad side
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] padPullupEn,
  // key side
  input  wire logic [7:0] keyDrive,
  input  wire logic [7:0] keyLevel,
  // resolved levels
  output logic [7:0]      padIn
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] floatLvl = 8'h00;

  // undriven lines wander so no stale level reads as valid
  always_ff @(posedge core_clk)
    floatLvl <= ~floatLvl;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (padOe[i])
        padIn[i] = padOut[i];
      else if (keyDrive[i])
        padIn[i] = keyLevel[i];
      else if (padPullupEn[i])
        padIn[i] = 1'b1;
      else
        padIn[i] = floatLvl[i];
    end
  end
endmodule

/* File: test/tb_port_pins_with_change_interrupts.sv */
// self-checking bench of the port-pin block
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_port_pins_with_change_interrupts;
  timeunit 1ns;
  timeprecision 1ps;

  logic                      core_clk;
  logic                      nrst = 1'b0;
  pcp_pkg::pcp_bus_req_type  busReq = '0;
  logic [7:0]                busRdata;
  logic [7:0]                padIn;
  logic [7:0]                padOut;
  logic [7:0]                padOe;
  logic [7:0]                padPullupEn;
  logic                      timerTick = 1'b0;
  logic                      intReq;
  logic                      halted;
  logic                      wakePulse;
  logic                      vectorJump;
  logic [7:0]                keyDrive = 8'hFF;
  logic [7:0]                keyLevel = 8'h00;
  int                        mismatches = 0;
  int                        comparisons = 0;

  pcp_port_pins dut_u
  (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .busReq      (busReq),
    .busRdata    (busRdata),
    .padIn       (padIn),
    .padOut      (padOut),
    .padOe       (padOe),
    .padPullupEn (padPullupEn),
    .timerTick   (timerTick),
    .intReq      (intReq),
    .halted      (halted),
    .wakePulse   (wakePulse),
    .vectorJump  (vectorJump)
  );

  pcp_pin_model pin_u
  (
    .core_clk    (core_clk),
    .padOut      (padOut),
    .padOe       (padOe),
    .padPullupEn (padPullupEn),
    .keyDrive    (keyDrive),
    .keyLevel    (keyLevel),
    .padIn       (padIn)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic tk(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic key(input logic [7:0] v);
    @(posedge core_clk);
    keyLevel <= v;
  endtask

  task automatic wr(input logic [pcp_pkg::ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    busReq.wr <= 1'b0;
  endtask

  task automatic rc(input logic [pcp_pkg::ADDR_W-1:0] a, input logic [7:0] e,
                    input string n);
    @(posedge core_clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    @(negedge core_clk);
    `CHK(n, e, busRdata)
  endtask

  task automatic wake(input logic g);
    int n;
    n = 0;
    while (wakePulse !== 1'b1 && n < 12)
    begin
      @(negedge core_clk);
      n++;
    end
    `CHK("wake", 1'b1, wakePulse)
    `CHK("vector", g, vectorJump)
    tk(1);
    `CHK("halt", 1'b0, halted)
  endtask

  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    close_out;
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    tk(1);
    `CHK("oe", 8'h00, padOe)
    `CHK("pull", 8'h00, padPullupEn)
    rc(pcp_pkg::ADDR_DIR, pcp_pkg::RST_DIR, "dir");
    rc(pcp_pkg::ADDR_OPTION, pcp_pkg::RST_OPTION, "opt");
    rc(pcp_pkg::ADDR_INTCTL, pcp_pkg::RST_INTCTL, "ictl");
    // upper nibble driven from latch, lower from keys
    wr(pcp_pkg::ADDR_DIR, 8'h0F);
    wr(pcp_pkg::ADDR_PORT, 8'hA5);
    key(8'h3C);
    tk(5);
    `CHK("oe", 8'hF0, padOe)
    `CHK("out", 8'hA5, padOut)
    rc(pcp_pkg::ADDR_PORT, 8'hAC, "pins");
    wr(pcp_pkg::ADDR_PORT_SET, 8'h01);
    tk(5);
    `CHK("out", 8'hAD, padOut)
    wr(pcp_pkg::ADDR_PORT_CLR, 8'h80);
    tk(2);
    `CHK("out", 8'h2C, padOut)
    wr(pcp_pkg::ADDR_OPTION, 8'h7F);
    tk(3);
    `CHK("pull", 8'h0F, padPullupEn)
    wr(pcp_pkg::ADDR_OPTION, 8'hFF);
    tk(3);
    `CHK("pull", 8'h00, padPullupEn)
    // output pins changing under a stale compare value
    rc(pcp_pkg::ADDR_PORT, 8'h2C, "pins");
    wr(pcp_pkg::ADDR_INTCTL, 8'h00);
    wr(pcp_pkg::ADDR_PORT, 8'hF0);
    tk(6);
    rc(pcp_pkg::ADDR_INTCTL, 8'h00, "chg");
    wr(pcp_pkg::ADDR_DIR, 8'hFF);
    key(8'h00);
    tk(4);
    for (int i = 4; i < 8; i++)
    begin
      rc(pcp_pkg::ADDR_PORT, keyLevel, "pins");
      wr(pcp_pkg::ADDR_INTCTL, 8'h00);
      key(keyLevel ^ (8'h01 << i));
      tk(5);
      rc(pcp_pkg::ADDR_INTCTL, 8'h01, "chg");
    end
    wr(pcp_pkg::ADDR_INTCTL, 8'h00);
    rc(pcp_pkg::ADDR_INTCTL, 8'h01, "chg");
    wr(pcp_pkg::ADDR_INTCTL, 8'h89);
    tk(2);
    `CHK("irq", 1'b1, intReq)
    wr(pcp_pkg::ADDR_INTCTL, 8'h81);
    tk(2);
    `CHK("irq", 1'b0, intReq)
    rc(pcp_pkg::ADDR_PORT, 8'hF0, "pins");
    wr(pcp_pkg::ADDR_INTCTL, 8'h00);
    rc(pcp_pkg::ADDR_INTCTL, 8'h00, "chg");
    // selected edge sets, opposite edge does not
    for (int s = 1; s >= 0; s--)
    begin
      wr(pcp_pkg::ADDR_OPTION, s ? 8'hFF : 8'hBF);
      key({keyLevel[7:1], ~s[0]});
      tk(4);
      wr(pcp_pkg::ADDR_INTCTL, 8'h00);
      key({keyLevel[7:1], s[0]});
      tk(5);
      rc(pcp_pkg::ADDR_INTCTL, 8'h02, "ext");
      wr(pcp_pkg::ADDR_INTCTL, 8'h00);
      key({keyLevel[7:1], ~s[0]});
      tk(5);
      rc(pcp_pkg::ADDR_INTCTL, 8'h00, "ext");
    end
    key({keyLevel[7:1], 1'b0});
    tk(5);
    wr(pcp_pkg::ADDR_INTCTL, 8'h82);
    tk(2);
    `CHK("irq", 1'b0, intReq)
    wr(pcp_pkg::ADDR_INTCTL, 8'h92);
    tk(2);
    `CHK("irq", 1'b1, intReq)
    wr(pcp_pkg::ADDR_INTCTL, 8'h00);
    wr(pcp_pkg::ADDR_TIMER, 8'hFE);
    @(posedge core_clk);
    timerTick <= 1'b1;
    repeat (2) @(posedge core_clk);
    timerTick <= 1'b0;
    tk(2);
    rc(pcp_pkg::ADDR_INTCTL, 8'h04, "wrap");
    rc(pcp_pkg::ADDR_TIMER, 8'h00, "cnt");
    wr(pcp_pkg::ADDR_INTCTL, 8'hA4);
    tk(2);
    `CHK("irq", 1'b1, intReq)
    wr(pcp_pkg::ADDR_INTCTL, 8'h84);
    tk(2);
    `CHK("irq", 1'b0, intReq)
    // wake on key press, with and without global enable
    for (int g = 1; g >= 0; g--)
    begin
      rc(pcp_pkg::ADDR_PORT, keyLevel, "pins");
      wr(pcp_pkg::ADDR_INTCTL, {g[0], 7'h08});
      wr(pcp_pkg::ADDR_POWER, 8'h01);
      tk(1);
      `CHK("halt", 1'b1, halted)
      key(keyLevel ^ 8'h80);
      wake(g[0]);
    end
    // ext enable set only after halt entry
    rc(pcp_pkg::ADDR_PORT, keyLevel, "pins");
    wr(pcp_pkg::ADDR_INTCTL, 8'h00);
    key({keyLevel[7:1], 1'b1});
    tk(4);
    wr(pcp_pkg::ADDR_POWER, 8'h01);
    wr(pcp_pkg::ADDR_INTCTL, 8'h10);
    key({keyLevel[7:1], 1'b0});
    tk(6);
    `CHK("halt", 1'b1, halted)
    rc(pcp_pkg::ADDR_POWER, 8'h01, "pwr");
    wr(pcp_pkg::ADDR_INTCTL, 8'h08);
    key(keyLevel ^ 8'h80);
    wake(1'b0);
    close_out;
  end
endmodule
